// [design/ibr_pkg.sv]
// Purpose: shared constants for the bridge function-modification registers
// Assumes: byte addressing on a 12-bit register window, 32-bit data
// Notes:   every offset, width, reset value and field position lives here
package ibr_pkg;

    // register byte offsets
    localparam logic [11:0] MERGE_BYP_OFS = 12'h024;
    localparam logic [11:0] LONG_BURST_OFS = 12'h02C;
    localparam logic [11:0] WR_THR_OFS = 12'h040;
    localparam logic [11:0] ISSUE_OFS = 12'h108;

    // register widths
    localparam int MERGE_W = 1;
    localparam int LONG_W = 1;
    localparam int THR_W = 4;
    localparam int ISSUE_W = 2;

    // reset values of the fixed-reset registers and the default threshold configuration
    localparam logic [0:0] MERGE_RST = 1'h0;
    localparam logic [0:0] LONG_RST = 1'h0;
    localparam logic [1:0] ISSUE_RST = 2'h0;
    localparam logic [3:0] THR_CFG_DEF = 4'h4;

    // field positions in the issue override register
    localparam int RD_OVR_BIT = 0;
    localparam int WR_OVR_BIT = 1;

    // burst length ceilings handed to the burst breaker
    localparam int BLEN_W = 9;
    localparam logic [8:0] LONG_BURST_LEN = 9'h100;
    localparam logic [8:0] SHORT_BURST_LEN = 9'h010;

    // outstanding-transaction counter width and default capability
    localparam int CAP_W = 4;
    localparam logic [3:0] ISSUE_CAP_DEF = 4'h8;
    localparam logic [3:0] ISSUE_CAP_ONE = 4'h1;

    // bus slave states
    typedef enum logic {
        ST_IDLE,
        ST_ACK
    } ibr_bus_st_t;

endpackage : ibr_pkg

// [design/ibr_ctrl_field.sv]
// Purpose: one software-writable control field with a configurable presence
// Assumes: write enable already qualified by address decode and handshake
// Notes:   an absent field never leaves its reset value
`timescale 1ns/1ps
`default_nettype none

module ibr_ctrl_field #(
    parameter int W = 1,
    parameter bit PRESENT = 1'b1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] value_o
);

    logic [W-1:0] value_q;

    // storage; absent fields ignore writes so they keep the default
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            value_q <= RST;
        end else if (PRESENT && wr_en_i) begin
            value_q <= wdata_i;
        end
    end

    assign value_o = value_q;

    // absent field holds its reset value
    field_absent_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !PRESENT |-> value_q == RST)
        else $error("absent field moved off its reset value");

endmodule : ibr_ctrl_field

`default_nettype wire

// [design/ibr_issue_gate.sv]
// Purpose: outstanding-transaction limiter for one direction
// Assumes: issue and done pulses come from logic on the same clock
// Notes:   issue_ok is registered from the next count, so it agrees with count_q after every edge
`timescale 1ns/1ps
`default_nettype none

module ibr_issue_gate #(
    parameter logic [3:0] CAP = 4'h8
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic override_i,
    input wire logic issue_i,
    input wire logic done_i,
    output logic issue_ok_o
);

    logic [3:0] count_q;
    logic [3:0] count_d;
    logic [3:0] limit;
    logic issue_ok_q;

    // next count; a done with nothing outstanding is dropped
    always_comb begin
        count_d = count_q;
        if (issue_i && !done_i) begin
            count_d = count_q + 4'h1;
        end else if (done_i && !issue_i && count_q != 4'h0) begin
            count_d = count_q - 4'h1;
        end
    end

    // [R8] override caps at one
    assign limit = override_i ? ibr_pkg::ISSUE_CAP_ONE : CAP;

    // count and grant registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= 4'h0;
            issue_ok_q <= 1'b1;
        end else begin
            count_q <= count_d;
            issue_ok_q <= (count_d < limit);
        end
    end

    assign issue_ok_o = issue_ok_q;

    single_outstanding_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(override_i) && count_q != 4'h0 |-> !issue_ok_q) // [R8]
        else $error("second transaction allowed under override");

endmodule : ibr_issue_gate

`default_nettype wire

// [design/ibr_function_mod_regs.sv]
// Purpose: function-modification register bank of one bridge, Avalon-MM slave
// Assumes: one clock; register bus and datapath controls on sys_clk_i
// Notes:   every access takes one wait cycle; absent registers read as zero
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R1] A one-bit merge-bypass register, reset to zero, exists only when the bridge resizes.
// [R2] A one-bit long-burst register, reset to zero, exists only when downsizing to AXI4.
// [R3] While long-burst control is zero, bursts are broken so none are long at the output.
// [R4] While long-burst control is one, long bursts may pass to the output unsplit.
// [R5] Without the register interface the long-burst default applies and no long bursts.
// [R6] A four-bit write threshold register exists only with a write queue and a set value.
// [R7] The write threshold resets to the value chosen at configuration, not a constant.
// [R8] A two-bit issue override register resets to zero; a set bit allows one outstanding.
// [R9] Bit 0 of the issue override is the read direction and bit 1 the write direction.
// [R10] Reserved or absent registers read as zero and ignore writes.
module ibr_function_mod_regs #(
    parameter bit PV_PRESENT = 1'b1,
    parameter bit HAS_SIZER = 1'b1,
    parameter bit DOWNSIZE_AXI4 = 1'b1,
    parameter bit HAS_WRITE_DATA_QUEUE = 1'b1,
    parameter logic [3:0] THR_CFG = ibr_pkg::THR_CFG_DEF,
    parameter logic [3:0] RD_ISSUE_CAP = ibr_pkg::ISSUE_CAP_DEF,
    parameter logic [3:0] WR_ISSUE_CAP = ibr_pkg::ISSUE_CAP_DEF
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic rd_issue_i,
    input wire logic rd_done_i,
    input wire logic wr_issue_i,
    input wire logic wr_done_i,
    output logic merge_bypass_o,
    output logic long_burst_allow_o,
    output logic [8:0] burst_len_max_o,
    output logic [3:0] write_data_queue_threshold_o,
    output logic rd_override_o,
    output logic wr_override_o,
    output logic rd_issue_ok_o,
    output logic wr_issue_ok_o
);

    // presence of each register in this build
    localparam bit MERGE_PRESENT = PV_PRESENT && HAS_SIZER;
    localparam bit LONG_PRESENT = PV_PRESENT && DOWNSIZE_AXI4;
    localparam bit THR_PRESENT = PV_PRESENT && HAS_WRITE_DATA_QUEUE && (THR_CFG != 4'h0);
    localparam bit ISSUE_PRESENT = PV_PRESENT;

    ibr_pkg::ibr_bus_st_t st_q;
    logic req;
    logic wr_fire;
    logic hit_merge;
    logic hit_long;
    logic hit_thr;
    logic hit_issue;
    logic [31:0] rd_mux;
    logic [31:0] readdata_q;
    logic waitreq_q;
    logic merge_val;
    logic long_val;
    logic [3:0] thr_val;
    logic [1:0] issue_val;
    logic merge_q;
    logic long_q;
    logic [8:0] blen_q;
    logic [3:0] thr_q;
    logic rd_ovr_q;
    logic wr_ovr_q;
    logic rd_ok;
    logic wr_ok;

    // read and write are never high together, so either one is a request
    assign req = avs_read_i || avs_write_i;

    // word decode; a hit on an absent register counts as reserved
    assign hit_merge = MERGE_PRESENT && (avs_address_i[11:2] == ibr_pkg::MERGE_BYP_OFS[11:2]);
    assign hit_long = LONG_PRESENT && (avs_address_i[11:2] == ibr_pkg::LONG_BURST_OFS[11:2]);
    assign hit_thr = THR_PRESENT && (avs_address_i[11:2] == ibr_pkg::WR_THR_OFS[11:2]);
    assign hit_issue = ISSUE_PRESENT && (avs_address_i[11:2] == ibr_pkg::ISSUE_OFS[11:2]);

    // writes land only at the edge where waitrequest is seen low
    assign wr_fire = avs_write_i && (st_q == ibr_pkg::ST_ACK) && avs_byteenable_i[0];

    // bus handshake: one wait cycle, then a single low-waitrequest cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ibr_pkg::ST_IDLE;
            waitreq_q <= 1'b1;
        end else begin
            unique case (st_q)
                ibr_pkg::ST_IDLE: begin
                    if (req) begin
                        st_q <= ibr_pkg::ST_ACK;
                        waitreq_q <= 1'b0;
                    end
                end
                ibr_pkg::ST_ACK: begin
                    st_q <= ibr_pkg::ST_IDLE;
                    waitreq_q <= 1'b1;
                end
            endcase
        end
    end

    // [R10] read mux, zero elsewhere
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_merge) begin
            rd_mux[0] = merge_val;
        end
        if (hit_long) begin
            rd_mux[0] = long_val;
        end
        if (hit_thr) begin
            rd_mux[3:0] = thr_val;
        end
        if (hit_issue) begin
            rd_mux[1:0] = issue_val;
        end
    end

    // read data captured in the wait cycle and held through the answer
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            readdata_q <= 32'h0000_0000;
        end else if (st_q == ibr_pkg::ST_IDLE && avs_read_i) begin
            readdata_q <= rd_mux;
        end
    end

    assign avs_readdata_o = readdata_q;
    assign avs_waitrequest_o = waitreq_q;

    // [R1] merge-bypass storage
    ibr_ctrl_field #(
        .W(ibr_pkg::MERGE_W),
        .PRESENT(MERGE_PRESENT),
        .RST(ibr_pkg::MERGE_RST)
    ) u_merge (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .wr_en_i(wr_fire && hit_merge),
        .wdata_i(avs_writedata_i[0]),
        .value_o(merge_val)
    );

    // [R2] long-burst storage; [R5] absent without register access
    ibr_ctrl_field #(
        .W(ibr_pkg::LONG_W),
        .PRESENT(LONG_PRESENT),
        .RST(ibr_pkg::LONG_RST)
    ) u_long (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .wr_en_i(wr_fire && hit_long),
        .wdata_i(avs_writedata_i[0]),
        .value_o(long_val)
    );

    // [R6] [R7] threshold, reset from configuration
    ibr_ctrl_field #(
        .W(ibr_pkg::THR_W),
        .PRESENT(THR_PRESENT),
        .RST(THR_CFG)
    ) u_thr (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .wr_en_i(wr_fire && hit_thr),
        .wdata_i(avs_writedata_i[3:0]),
        .value_o(thr_val)
    );

    // [R8] issue override storage
    ibr_ctrl_field #(
        .W(ibr_pkg::ISSUE_W),
        .PRESENT(ISSUE_PRESENT),
        .RST(ibr_pkg::ISSUE_RST)
    ) u_issue (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .wr_en_i(wr_fire && hit_issue),
        .wdata_i(avs_writedata_i[1:0]),
        .value_o(issue_val)
    );

    // output copies of the fields, kept as flops for clean timing to the datapath
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            merge_q <= ibr_pkg::MERGE_RST;
            long_q <= ibr_pkg::LONG_RST;
            thr_q <= THR_CFG;
        end else begin
            merge_q <= merge_val;
            long_q <= long_val;
            thr_q <= thr_val;
        end
    end

    // [R3] [R4] burst ceiling for the burst breaker
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            blen_q <= ibr_pkg::SHORT_BURST_LEN;
        end else begin
            blen_q <= long_val ? ibr_pkg::LONG_BURST_LEN : ibr_pkg::SHORT_BURST_LEN;
        end
    end

    // [R9] split override bits by direction
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ovr_q <= 1'b0;
            wr_ovr_q <= 1'b0;
        end else begin
            rd_ovr_q <= issue_val[ibr_pkg::RD_OVR_BIT];
            wr_ovr_q <= issue_val[ibr_pkg::WR_OVR_BIT];
        end
    end

    // [R8] read-direction limiter; the override reaches it without the output flop
    ibr_issue_gate #(
        .CAP(RD_ISSUE_CAP)
    ) u_rd_gate (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .override_i(issue_val[ibr_pkg::RD_OVR_BIT]),
        .issue_i(rd_issue_i),
        .done_i(rd_done_i),
        .issue_ok_o(rd_ok)
    );

    // [R8] write-direction limiter
    ibr_issue_gate #(
        .CAP(WR_ISSUE_CAP)
    ) u_wr_gate (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .override_i(issue_val[ibr_pkg::WR_OVR_BIT]),
        .issue_i(wr_issue_i),
        .done_i(wr_done_i),
        .issue_ok_o(wr_ok)
    );

    // grants already come from flops inside the limiters
    assign merge_bypass_o = merge_q;
    assign long_burst_allow_o = long_q;
    assign burst_len_max_o = blen_q;
    assign write_data_queue_threshold_o = thr_q;
    assign rd_override_o = rd_ovr_q;
    assign wr_override_o = wr_ovr_q;
    assign rd_issue_ok_o = rd_ok;
    assign wr_issue_ok_o = wr_ok;

    // checks, all on the one clock
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_req_idle;
        req && st_q == ibr_pkg::ST_IDLE;
    endsequence

    sequence s_ack_one;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    sequence s_read_taken;
        avs_read_i && st_q == ibr_pkg::ST_IDLE;
    endsequence

    bus_wait_one_a: assert property (s_req_idle |=> s_ack_one) // [R10]
        else $error("waitrequest did not drop for exactly one cycle");

    merge_write_a: assert property ( // [R1]
        wr_fire && hit_merge |-> ##2 merge_bypass_o == $past(avs_writedata_i[0], 2))
        else $error("merge bypass did not take written value");

    merge_absent_a: assert property (!MERGE_PRESENT |-> !merge_bypass_o) // [R1]
        else $error("merge bypass set while absent");

    long_absent_a: assert property (!LONG_PRESENT |-> !long_burst_allow_o) // [R5]
        else $error("long bursts allowed while register absent");

    burst_break_a: assert property (!long_val |=> burst_len_max_o == ibr_pkg::SHORT_BURST_LEN) // [R3]
        else $error("burst ceiling not short with long bursts off");

    burst_long_a: assert property (long_val |=> burst_len_max_o == ibr_pkg::LONG_BURST_LEN) // [R4]
        else $error("burst ceiling not long with long bursts on");

    thr_write_a: assert property ( // [R6]
        wr_fire && hit_thr |-> ##2 write_data_queue_threshold_o == $past(avs_writedata_i[3:0], 2))
        else $error("threshold did not take written value");

    thr_absent_a: assert property (!THR_PRESENT |-> write_data_queue_threshold_o == THR_CFG) // [R7]
        else $error("absent threshold left its configured value");

    issue_bits_a: assert property ( // [R9]
        wr_fire && hit_issue |-> ##2
        rd_override_o == $past(avs_writedata_i[ibr_pkg::RD_OVR_BIT], 2) &&
        wr_override_o == $past(avs_writedata_i[ibr_pkg::WR_OVR_BIT], 2))
        else $error("override bits not mapped read low, write high");

    reserved_zero_a: assert property ( // [R10]
        st_q == ibr_pkg::ST_ACK && avs_read_i &&
        !(hit_merge || hit_long || hit_thr || hit_issue) |-> avs_readdata_o == 32'h0000_0000)
        else $error("reserved offset read nonzero");

    reserved_nowrite_a: assert property ( // [R10]
        wr_fire && !(hit_merge || hit_long || hit_thr || hit_issue) |=>
        $stable(merge_val) && $stable(long_val) && $stable(thr_val) && $stable(issue_val))
        else $error("reserved write changed a register");

    // [R10] read data is the mux value of the taken cycle
    read_capture_a: assert property (s_read_taken |=> avs_readdata_o == $past(rd_mux)) // [R10]
        else $error("read data not captured in the wait cycle");

    // [R8] override moves only on an acknowledged write to it
    issue_hold_a: assert property (!(wr_fire && hit_issue) |=> $stable(issue_val)) // [R8]
        else $error("issue override changed without a write");

    // [R1] bypass moves only on an acknowledged write to it
    merge_hold_a: assert property (!(wr_fire && hit_merge) |=> $stable(merge_val)) // [R1]
        else $error("merge bypass changed without a write");

    // [R2] long-burst control moves only on an acknowledged write to it
    long_hold_a: assert property (!(wr_fire && hit_long) |=> $stable(long_val)) // [R2]
        else $error("long burst control changed without a write");

    // [R7] first edge after release shows the configured threshold and short bursts
    reset_values_a: assert property ($fell(rst_i) |-> // [R7]
        write_data_queue_threshold_o == THR_CFG && burst_len_max_o == ibr_pkg::SHORT_BURST_LEN)
        else $error("controls not at reset values after release");

endmodule : ibr_function_mod_regs

`default_nettype wire

// [verif/tb_top.sv]
// Purpose: self-checking bench for the bridge function-modification registers
// Assumes: a full build and one without register access, threshold configured to 9
// Notes:   bus tasks wait on waitrequest under a bound; read data sampled at posedge, other outputs at negedge
`timescale 1ns/1ps
`default_nettype none

module tb_top;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } ibr_tb_row_t;

    // non-default threshold proves reset loads the configured value
    localparam logic [3:0] TB_THR = 4'h9;
    localparam int WAIT_MAX = 50;
    // write then read back; absent offsets must stay zero
    localparam ibr_tb_row_t ROWS [9] = '{
        '{ibr_pkg::MERGE_BYP_OFS, 32'hFFFFFFFF, 32'h00000001},
        '{ibr_pkg::LONG_BURST_OFS, 32'hFFFFFFFF, 32'h00000001},
        '{ibr_pkg::WR_THR_OFS, 32'hFFFFFFF5, 32'h00000005},
        '{ibr_pkg::ISSUE_OFS, 32'hFFFFFFFE, 32'h00000002},
        '{12'h028, 32'hFFFFFFFF, 32'h00000000},
        '{12'h044, 32'hFFFFFFFF, 32'h00000000},
        '{12'h100, 32'hFFFFFFFF, 32'h00000000},
        '{12'h10C, 32'hFFFFFFFF, 32'h00000000},
        '{12'hFFC, 32'hFFFFFFFF, 32'h00000000}
    };

    logic sys_clk_i;
    logic rst_i;
    logic [11:0] avs_address_i;
    logic avs_read_i;
    logic avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0] avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic rd_issue_i;
    logic rd_done_i;
    logic wr_issue_i;
    logic wr_done_i;
    logic merge_bypass_o;
    logic long_burst_allow_o;
    logic [8:0] burst_len_max_o;
    logic [3:0] write_data_queue_threshold_o;
    logic rd_override_o;
    logic wr_override_o;
    logic rd_issue_ok_o;
    logic wr_issue_ok_o;
    int failures;
    int checks_done;
    logic [31:0] rdata;
    // outputs of the build without register access
    logic [31:0] nopv_rdata;
    logic nopv_merge;
    logic nopv_long;
    logic [8:0] nopv_blen;
    logic [3:0] nopv_thr;
    logic nopv_rovr;
    logic nopv_wovr;
    logic nopv_rok;
    logic nopv_wok;

    ibr_function_mod_regs #(
        .THR_CFG(TB_THR)
    ) u_ibr_function_mod_regs (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .rd_issue_i(rd_issue_i),
        .rd_done_i(rd_done_i),
        .wr_issue_i(wr_issue_i),
        .wr_done_i(wr_done_i),
        .merge_bypass_o(merge_bypass_o),
        .long_burst_allow_o(long_burst_allow_o),
        .burst_len_max_o(burst_len_max_o),
        .write_data_queue_threshold_o(write_data_queue_threshold_o),
        .rd_override_o(rd_override_o),
        .wr_override_o(wr_override_o),
        .rd_issue_ok_o(rd_issue_ok_o),
        .wr_issue_ok_o(wr_issue_ok_o)
    );

    // no register interface: every read is zero and controls keep their defaults
    ibr_function_mod_regs #(
        .PV_PRESENT(1'b0),
        .THR_CFG(TB_THR)
    ) u_ibr_function_mod_regs_nopv (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(nopv_rdata),
        .avs_waitrequest_o(),
        .rd_issue_i(rd_issue_i),
        .rd_done_i(rd_done_i),
        .wr_issue_i(wr_issue_i),
        .wr_done_i(wr_done_i),
        .merge_bypass_o(nopv_merge),
        .long_burst_allow_o(nopv_long),
        .burst_len_max_o(nopv_blen),
        .write_data_queue_threshold_o(nopv_thr),
        .rd_override_o(nopv_rovr),
        .wr_override_o(nopv_wovr),
        .rd_issue_ok_o(nopv_rok),
        .wr_issue_ok_o(nopv_wok)
    );

    // 25 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // verdict and end of run, shared by the main sequence and timeouts
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one Avalon transfer; request held until waitrequest is seen low at an edge
    task automatic bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                            input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        @(posedge sys_clk_i);
        while (avs_waitrequest_o !== 1'b0 && n < WAIT_MAX) begin
            @(posedge sys_clk_i);
            n++;
        end
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= WAIT_MAX) begin
            failures++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, n, 32'h00000000);
            end_sim();
        end
        // one idle edge, so a following call never re-raises in this time step
        @(posedge sys_clk_i);
    endtask : bus_xfer

    // write, then let the output copies land two edges later
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus_xfer(1'b1, a, d, 4'hF, dummy);
        repeat (2) @(posedge sys_clk_i);
    endtask : reg_wr

    // pulse one issue or done cycle on both directions
    task automatic pulse(input logic iss);
        @(posedge sys_clk_i);
        rd_issue_i <= iss;
        wr_issue_i <= iss;
        rd_done_i <= ~iss;
        wr_done_i <= ~iss;
        @(posedge sys_clk_i);
        {rd_issue_i, wr_issue_i, rd_done_i, wr_done_i} <= 4'h0;
        @(negedge sys_clk_i);
    endtask : pulse

    // main sequence
    initial begin
        failures = 0;
        checks_done = 0;
        rst_i = 1'b1;
        avs_address_i = 12'h000;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h00000000;
        avs_byteenable_i = 4'hF;
        {rd_issue_i, wr_issue_i, rd_done_i, wr_done_i} = 4'h0;
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        // reset values through the bus
        bus_xfer(1'b0, ibr_pkg::MERGE_BYP_OFS, 32'h0, 4'hF, rdata);
        chk(rdata, 32'h00000000);
        bus_xfer(1'b0, ibr_pkg::LONG_BURST_OFS, 32'h0, 4'hF, rdata);
        chk(rdata, 32'h00000000);
        bus_xfer(1'b0, ibr_pkg::WR_THR_OFS, 32'h0, 4'hF, rdata);
        chk(rdata, 32'(TB_THR));
        chk(nopv_rdata, 32'h00000000);
        bus_xfer(1'b0, ibr_pkg::ISSUE_OFS, 32'h0, 4'hF, rdata);
        chk(rdata, 32'h00000000);
        @(negedge sys_clk_i);
        chk(32'(burst_len_max_o), 32'h00000010);
        chk(32'(write_data_queue_threshold_o), 32'(TB_THR));
        // table rows: write then read back, the bare build always reads zero
        @(posedge sys_clk_i);
        for (int i = 0; i < 9; i++) begin
            bus_xfer(1'b1, ROWS[i].addr, ROWS[i].wdata, 4'hF, rdata);
            bus_xfer(1'b0, ROWS[i].addr, 32'h0, 4'hF, rdata);
            chk(rdata, ROWS[i].exp);
            chk(nopv_rdata, 32'h00000000);
        end
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk(32'(merge_bypass_o), 32'h00000001);
        chk(32'(long_burst_allow_o), 32'h00000001);
        chk(32'(burst_len_max_o), 32'h00000100);
        chk(32'(write_data_queue_threshold_o), 32'h00000005);
        // the build without register access ignored the same writes
        chk(32'({nopv_merge, nopv_long, nopv_wovr, nopv_rovr}), 32'h00000000);
        chk(32'(nopv_blen), 32'h00000010);
        chk(32'(nopv_thr), 32'(TB_THR));
        // byte lane 0 off: write acknowledged but ignored
        @(posedge sys_clk_i);
        bus_xfer(1'b1, ibr_pkg::MERGE_BYP_OFS, 32'h00000000, 4'hE, rdata);
        bus_xfer(1'b0, ibr_pkg::MERGE_BYP_OFS, 32'h0, 4'hF, rdata);
        chk(rdata, 32'h00000001);
        // long bursts off again restores the short ceiling
        reg_wr(ibr_pkg::LONG_BURST_OFS, 32'h00000000);
        @(negedge sys_clk_i);
        chk(32'(long_burst_allow_o), 32'h00000000);
        chk(32'(burst_len_max_o), 32'h00000010);
        // each override bit limits only its own direction to one outstanding
        for (int b = 0; b < 2; b++) begin
            @(posedge sys_clk_i);
            reg_wr(ibr_pkg::ISSUE_OFS, 32'h00000001 << b);
            @(negedge sys_clk_i);
            chk(32'({wr_override_o, rd_override_o}), 32'h00000001 << b);
            chk(32'({nopv_wovr, nopv_rovr}), 32'h00000000);
            pulse(1'b1);
            chk(32'(rd_issue_ok_o), 32'(b != 0));
            chk(32'(wr_issue_ok_o), 32'(b == 0));
            chk(32'({nopv_wok, nopv_rok}), 32'h00000003);
            pulse(1'b0);
            chk(32'({wr_issue_ok_o, rd_issue_ok_o}), 32'h00000003);
        end
        // leave one transaction outstanding each way under override
        @(posedge sys_clk_i);
        reg_wr(ibr_pkg::ISSUE_OFS, 32'h00000003);
        pulse(1'b1);
        chk(32'({wr_issue_ok_o, rd_issue_ok_o}), 32'h00000000);
        // second reset in mid-run brings every control and count back
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk(32'({merge_bypass_o, long_burst_allow_o}), 32'h00000000);
        chk(32'({wr_override_o, rd_override_o}), 32'h00000000);
        chk(32'({wr_issue_ok_o, rd_issue_ok_o}), 32'h00000003);
        chk(32'(write_data_queue_threshold_o), 32'(TB_THR));
        chk(32'(burst_len_max_o), 32'h00000010);
        // first request in the second cycle after release
        @(posedge sys_clk_i);
        bus_xfer(1'b0, ibr_pkg::WR_THR_OFS, 32'h0, 4'hF, rdata);
        chk(rdata, 32'(TB_THR));
        end_sim();
    end

endmodule : tb_top

`default_nettype wire
